/* verilog/ccio_pkg.sv */
package ccio_pkg;
	// register byte addresses
	localparam logic [7:0] OFS_IO_HIGH = 8'h00;
	localparam logic [7:0] OFS_IO_LOW = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_GR_B = 8'h0C;
	localparam logic [7:0] OFS_GR_D = 8'h10;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
	// field positions inside the io control registers
	localparam int FLD_HI_LSB = 4;
	localparam int FLD_LO_LSB = 0;
	localparam int FLD_W = 4;
	// bits inside a 4-bit function field
	localparam int FB_CAPTURE = 3;
	localparam int FB_LEVEL = 2;
	localparam int FB_EDGE_BOTH = 1;
	localparam int FB_EDGE_FALL = 0;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;
	// control register layout
	localparam int CTRL_START = 0;
	localparam int CTRL_BUF_B = 1;
	localparam int CTRL_PSC_LSB = 2;
	localparam int CTRL_W = 5;
	localparam logic [2:0] PSC_UNDIVIDED = 3'h0;
	// interrupt status layout
	localparam int IRQ_MATCH_B = 0;
	localparam int IRQ_CAP_B = 1;
	localparam int IRQ_MATCH_D = 2;
	localparam int IRQ_CAP_D = 3;
	localparam int IRQ_W = 4;
	// reset values
	localparam logic [7:0] IOCTL_RST = 8'h00;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	localparam logic [31:0] GR_RST = 32'h0000_0000;
	localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} ccio_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} ccio_axi_rsp_s;
endpackage : ccio_pkg

/* verilog/ccio_top.sv */
// What this block does
// R1 - field top bit 0 selects output compare, 1 selects input capture
// R2 - compare codes set initial pin level from bit 6; 0000 and 0100 disable output
// R3 - compare code low bits 01 drive pin low at compare match
// R4 - compare code low bits 10 drive pin high at compare match
// R5 - compare code low bits 11 toggle pin at compare match
// R6 - pin capture with bit 6 zero: bits 5:4 00 rising, 01 falling edge
// R7 - pin capture with bit 5 set captures on both edges, bit 4 ignored
// R8 - bits 7 and 6 set capture counter on each channel 1 count step
// R9 - channel 1 count capture never fires while its prescale select is 000
// R10 - buffer mode B set: register D makes no compare match and no capture
// R11 - low control register bits 7:4 hold D field, read/write, reset 0
// R12 - low control register bits 3:0 hold C field, read/write, reset 0
// R13 - initial pin level applies while the counter start bit is 0
// R14 - compare match is the cycle where counter equals compare register
`timescale 1ns/10ps
module ccio_top #(
	parameter int CNT_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// register bus
	input wire ccio_pkg::ccio_axi_req_s axiReq,
	output ccio_pkg::ccio_axi_rsp_s axiRsp,
	// timer pins, index 0 = pin B, 1 = pin D
	input wire logic [1:0] timerPinIn,
	output logic [1:0] timerPinOut,
	output logic [1:0] timerPinOe,
	// counters
	input wire logic [CNT_W-1:0] counterCh0,
	input wire logic ch1CountPulse,
	// interrupt
	output logic irq
);
	ccio_pkg::ccio_axi_rsp_s axiRsp_ff;
	logic awHeld_ff;
	logic wHeld_ff;
	logic [7:0] awAddr_ff;
	logic [31:0] wData_ff;
	logic [3:0] wStrb_ff;
	logic [7:0] ioHigh_ff;
	logic [7:0] ioLow_ff;
	logic [ccio_pkg::CTRL_W-1:0] ctrl_ff;
	logic [ccio_pkg::IRQ_W-1:0] irqStat_ff;
	logic [ccio_pkg::IRQ_W-1:0] irqMask_ff;
	logic [ccio_pkg::IRQ_W-1:0] nxt_irqStat;
	logic irq_ff;
	logic [1:0] pinS1_ff;
	logic [1:0] pinS2_ff;
	logic [1:0] pinS3_ff;
	logic wrEn;
	logic wrHit;
	logic rdHit;
	logic [31:0] rdData;
	logic [ccio_pkg::FLD_W-1:0] fld [2];
	logic [CNT_W-1:0] grVal [2];
	logic [1:0] matchEv;
	logic [1:0] capEv;
	logic [1:0] wrGr;
	logic counterRun;
	logic bufModeB;
	logic [2:0] prescaleSel;
	logic ch1Ev;

	assign axiRsp = axiRsp_ff;
	assign irq = irq_ff;
	assign counterRun = ctrl_ff[ccio_pkg::CTRL_START];
	assign bufModeB = ctrl_ff[ccio_pkg::CTRL_BUF_B];
	assign prescaleSel = ctrl_ff[ccio_pkg::CTRL_PSC_LSB +: 3];
	assign fld[0] = ioHigh_ff[ccio_pkg::FLD_HI_LSB +: ccio_pkg::FLD_W];
	assign fld[1] = ioLow_ff[ccio_pkg::FLD_HI_LSB +: ccio_pkg::FLD_W];
	assign wrEn = awHeld_ff && wHeld_ff && !axiRsp_ff.bvalid;
	// undivided count clock gives no capture source
	assign ch1Ev = ch1CountPulse && (prescaleSel != ccio_pkg::PSC_UNDIVIDED); // R9

	// address decode
	always_comb
	begin
		wrHit = (awAddr_ff == ccio_pkg::OFS_IO_HIGH) || (awAddr_ff == ccio_pkg::OFS_IO_LOW)
			|| (awAddr_ff == ccio_pkg::OFS_CTRL) || (awAddr_ff == ccio_pkg::OFS_GR_B)
			|| (awAddr_ff == ccio_pkg::OFS_GR_D) || (awAddr_ff == ccio_pkg::OFS_IRQ_STAT)
			|| (awAddr_ff == ccio_pkg::OFS_IRQ_MASK);
		wrGr[0] = wrEn && wStrb_ff[0] && (awAddr_ff == ccio_pkg::OFS_GR_B);
		wrGr[1] = wrEn && wStrb_ff[0] && (awAddr_ff == ccio_pkg::OFS_GR_D);
		rdHit = 1'b1;
		rdData = 32'h0000_0000;
		if (axiReq.araddr == ccio_pkg::OFS_IO_HIGH)
			rdData[7:0] = ioHigh_ff;
		else if (axiReq.araddr == ccio_pkg::OFS_IO_LOW)
			rdData[7:0] = ioLow_ff; // R11 R12
		else if (axiReq.araddr == ccio_pkg::OFS_CTRL)
			rdData[ccio_pkg::CTRL_W-1:0] = ctrl_ff;
		else if (axiReq.araddr == ccio_pkg::OFS_GR_B)
			rdData[CNT_W-1:0] = grVal[0];
		else if (axiReq.araddr == ccio_pkg::OFS_GR_D)
			rdData[CNT_W-1:0] = grVal[1];
		else if (axiReq.araddr == ccio_pkg::OFS_IRQ_STAT)
			rdData[ccio_pkg::IRQ_W-1:0] = irqStat_ff;
		else if (axiReq.araddr == ccio_pkg::OFS_IRQ_MASK)
			rdData[ccio_pkg::IRQ_W-1:0] = irqMask_ff;
		else
			rdHit = 1'b0;
	end

	// axi write and read channels
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			axiRsp_ff <= '0;
			axiRsp_ff.awready <= 1'b1;
			axiRsp_ff.wready <= 1'b1;
			axiRsp_ff.arready <= 1'b1;
			awHeld_ff <= 1'b0;
			wHeld_ff <= 1'b0;
			awAddr_ff <= 8'h00;
			wData_ff <= 32'h0000_0000;
			wStrb_ff <= 4'h0;
		end
		else
		begin
			if (axiReq.awvalid && axiRsp_ff.awready)
			begin
				awHeld_ff <= 1'b1;
				awAddr_ff <= axiReq.awaddr;
				axiRsp_ff.awready <= 1'b0;
			end
			if (axiReq.wvalid && axiRsp_ff.wready)
			begin
				wHeld_ff <= 1'b1;
				wData_ff <= axiReq.wdata;
				wStrb_ff <= axiReq.wstrb;
				axiRsp_ff.wready <= 1'b0;
			end
			if (wrEn)
			begin
				awHeld_ff <= 1'b0;
				wHeld_ff <= 1'b0;
				axiRsp_ff.bvalid <= 1'b1;
				axiRsp_ff.bresp <= wrHit ? ccio_pkg::RESP_OKAY : ccio_pkg::RESP_DECERR;
			end
			if (axiRsp_ff.bvalid && axiReq.bready)
			begin
				axiRsp_ff.bvalid <= 1'b0;
				axiRsp_ff.awready <= 1'b1;
				axiRsp_ff.wready <= 1'b1;
			end
			if (axiReq.arvalid && axiRsp_ff.arready)
			begin
				axiRsp_ff.arready <= 1'b0;
				axiRsp_ff.rvalid <= 1'b1;
				axiRsp_ff.rdata <= rdData;
				axiRsp_ff.rresp <= rdHit ? ccio_pkg::RESP_OKAY : ccio_pkg::RESP_DECERR;
			end
			if (axiRsp_ff.rvalid && axiReq.rready)
			begin
				axiRsp_ff.rvalid <= 1'b0;
				axiRsp_ff.arready <= 1'b1;
			end
		end
	end

	// control and io control registers
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ioHigh_ff <= ccio_pkg::IOCTL_RST;
			ioLow_ff <= ccio_pkg::IOCTL_RST; // R11 R12
			ctrl_ff <= ccio_pkg::CTRL_RST;
			irqMask_ff <= ccio_pkg::IRQ_RST;
		end
		else if (wrEn && wStrb_ff[0])
		begin
			if (awAddr_ff == ccio_pkg::OFS_IO_HIGH)
				ioHigh_ff <= wData_ff[7:0];
			else if (awAddr_ff == ccio_pkg::OFS_IO_LOW)
				ioLow_ff <= wData_ff[7:0]; // R11 R12
			else if (awAddr_ff == ccio_pkg::OFS_CTRL)
				ctrl_ff <= wData_ff[ccio_pkg::CTRL_W-1:0];
			else if (awAddr_ff == ccio_pkg::OFS_IRQ_MASK)
				irqMask_ff <= wData_ff[ccio_pkg::IRQ_W-1:0];
		end
	end

	// pin synchronisers; third stage only feeds edge detection
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pinS1_ff <= 2'h0;
			pinS2_ff <= 2'h0;
			pinS3_ff <= 2'h0;
		end
		else
		begin
			pinS1_ff <= timerPinIn;
			pinS2_ff <= pinS1_ff;
			pinS3_ff <= pinS2_ff;
		end
	end

	// per-register function: index 0 = B, 1 = D
	for (genvar i = 0; i < 2; i++)
	begin : g_ch
		logic active;
		logic isCap;
		logic rise;
		logic fall;
		logic pinEv;
		logic outVal_ff;
		logic outEn_ff;
		logic [CNT_W-1:0] gr_ff;

		assign active = (i == 0) || !bufModeB; // R10
		assign isCap = fld[i][ccio_pkg::FB_CAPTURE]; // R1
		assign rise = pinS2_ff[i] && !pinS3_ff[i];
		assign fall = !pinS2_ff[i] && pinS3_ff[i];
		always_comb
		begin
			if (fld[i][ccio_pkg::FB_EDGE_BOTH])
				pinEv = rise || fall; // R7
			else if (fld[i][ccio_pkg::FB_EDGE_FALL])
				pinEv = fall; // R6
			else
				pinEv = rise; // R6
		end
		assign matchEv[i] = active && !isCap && counterRun && (counterCh0 == gr_ff); // R14
		assign capEv[i] = active && isCap
			&& (fld[i][ccio_pkg::FB_LEVEL] ? ch1Ev : pinEv); // R8
		assign grVal[i] = gr_ff;
		assign timerPinOut[i] = outVal_ff;
		assign timerPinOe[i] = outEn_ff;

		// capture beats a bus write in the same cycle
		always_ff @(posedge clk or posedge reset)
		begin
			if (reset)
				gr_ff <= ccio_pkg::GR_RST[CNT_W-1:0];
			else if (capEv[i])
				gr_ff <= counterCh0; // R6 R8
			else if (wrGr[i])
				gr_ff <= wData_ff[CNT_W-1:0];
		end

		always_ff @(posedge clk or posedge reset)
		begin
			if (reset)
			begin
				outVal_ff <= 1'b0;
				outEn_ff <= 1'b0;
			end
			else
			begin
				outEn_ff <= active && !isCap && (fld[i][1:0] != ccio_pkg::ACT_NONE); // R2
				if (!counterRun)
					outVal_ff <= fld[i][ccio_pkg::FB_LEVEL]; // R13 R2
				else if (matchEv[i])
				begin
					case (fld[i][1:0])
						ccio_pkg::ACT_LOW: outVal_ff <= 1'b0; // R3
						ccio_pkg::ACT_HIGH: outVal_ff <= 1'b1; // R4
						ccio_pkg::ACT_TOGGLE: outVal_ff <= !outVal_ff; // R5
						default: outVal_ff <= outVal_ff;
					endcase
				end
			end
		end
	end

	// sticky status, write one to clear, new events win
	always_comb
	begin
		nxt_irqStat = irqStat_ff;
		if (wrEn && wStrb_ff[0] && (awAddr_ff == ccio_pkg::OFS_IRQ_STAT))
			nxt_irqStat = irqStat_ff & ~wData_ff[ccio_pkg::IRQ_W-1:0];
		nxt_irqStat[ccio_pkg::IRQ_MATCH_B] = nxt_irqStat[ccio_pkg::IRQ_MATCH_B] | matchEv[0];
		nxt_irqStat[ccio_pkg::IRQ_CAP_B] = nxt_irqStat[ccio_pkg::IRQ_CAP_B] | capEv[0];
		nxt_irqStat[ccio_pkg::IRQ_MATCH_D] = nxt_irqStat[ccio_pkg::IRQ_MATCH_D] | matchEv[1];
		nxt_irqStat[ccio_pkg::IRQ_CAP_D] = nxt_irqStat[ccio_pkg::IRQ_CAP_D] | capEv[1];
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			irqStat_ff <= ccio_pkg::IRQ_RST;
			irq_ff <= 1'b0;
		end
		else
		begin
			irqStat_ff <= nxt_irqStat;
			irq_ff <= |(nxt_irqStat & irqMask_ff);
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence seqMatchB;
		matchEv[0] && counterRun;
	endsequence
	sequence seqRiseB;
		pinS2_ff[0] && !pinS3_ff[0];
	endsequence

	a_match_drive_low: assert property (seqMatchB ##0 (fld[0][1:0] == 2'h1) |=> !timerPinOut[0]) // R3
		else $error("pin B not low after match");
	a_match_drive_high: assert property (seqMatchB ##0 (fld[0][1:0] == 2'h2) |=> timerPinOut[0]) // R4
		else $error("pin B not high after match");
	a_match_toggle_pin: assert property ((matchEv[1] && fld[1][1:0] == 2'h3 && counterRun)
		|=> timerPinOut[1] != $past(timerPinOut[1])) // R5
		else $error("pin D did not toggle");
	a_stopped_init_level: assert property (!counterRun ##1 !counterRun
		|-> timerPinOut[0] == $past(fld[0][2])) // R13
		else $error("initial level wrong while stopped");
	a_disabled_output_off: assert property ((fld[0][1:0] == 2'h0) |=> !timerPinOe[0]) // R2
		else $error("pin B driven with output disabled");
	a_capture_mode_release: assert property (fld[1][3] |=> !timerPinOe[1]) // R1
		else $error("pin D driven in capture mode");
	a_rise_capture_value: assert property (seqRiseB ##0 (fld[0] == 4'h8)
		|=> grVal[0] == $past(counterCh0)) // R6
		else $error("rising edge capture value wrong");
	a_both_edge_flag: assert property ((fld[0][3:1] == 3'b101) && (pinS2_ff[0] != pinS3_ff[0])
		|=> irqStat_ff[1]) // R7
		else $error("both edge capture missed");
	a_ch1_count_capture: assert property ((fld[0][3:2] == 2'b11) && ch1CountPulse
		&& (prescaleSel != 3'h0) |=> irqStat_ff[1] ##0 grVal[0] == $past(counterCh0)) // R8
		else $error("channel 1 count capture missed");
	a_undivided_no_capture: assert property ((prescaleSel == 3'h0) && fld[0][2] |-> !capEv[0]) // R9
		else $error("capture with undivided count clock");
	a_buffer_d_silent: assert property (bufModeB |-> !capEv[1] && !matchEv[1]) // R10
		else $error("register D active in buffer mode");
	a_low_reg_write: assert property (wrEn && wStrb_ff[0] && awAddr_ff == 8'h04
		|=> ioLow_ff == $past(wData_ff[7:0])) // R11
		else $error("low io control write lost");
	// irq lags a mask write by one cycle, so only check it against a settled mask
	a_irq_follows_stat: assert property ($stable(irqMask_ff)
		|-> irq == (|(irqStat_ff & irqMask_ff)))
		else $error("interrupt level does not follow masked status");
endmodule : ccio_top

/* test/ccio_far_model.sv */
`timescale 1ns/10ps
module ccio_far_model #(
	parameter int CNT_W = 16
) (
	// clock
	input wire logic clk,
	// bench controls
	input wire logic run,
	input wire logic [1:0] pinDrv,
	// block side
	input wire logic [1:0] pinOut,
	input wire logic [1:0] pinOe,
	output logic [1:0] pinIn,
	output logic [CNT_W-1:0] count,
	output logic stepPulse
);
	logic [CNT_W-1:0] countFf;
	logic [1:0] divFf;
	logic stepFf;
	// a driven pin reads back the block's level, otherwise the outside source
	assign pinIn = (pinOe & pinOut) | (~pinOe & pinDrv);
	assign count = countFf;
	assign stepPulse = stepFf;
	// counter clears while stopped; channel 1 steps every fourth cycle
	always_ff @(posedge clk)
	begin
		countFf <= run ? countFf + 1'b1 : '0;
		divFf <= run ? divFf + 2'h1 : 2'h0;
		stepFf <= run && (divFf == 2'h3);
	end
endmodule : ccio_far_model

/* test/tb_compare_capture_io_control.sv */
`timescale 1ns/10ps
module tb_compare_capture_io_control;
	logic clk;
	logic reset;
	logic run;
	logic [1:0] pinDrv;
	ccio_pkg::ccio_axi_req_s req;
	ccio_pkg::ccio_axi_rsp_s rsp;
	logic [1:0] pinIn;
	logic [1:0] pinOut;
	logic [1:0] pinOe;
	logic [15:0] count;
	logic step;
	logic irq;
	int errTotal;
	int nCompared;
	logic [31:0] rdv;
	logic [1:0] rsv;
	logic [1:0] wrResp;
	logic [3:0] code;
	logic [7:0] v;
	logic bufD;
	logic [3:0] cmpCodes [4] = '{4'h5, 4'h2, 4'h3, 4'h7};

	ccio_top #(.CNT_W(16)) ccio_top_i (.clk(clk), .reset(reset), .axiReq(req), .axiRsp(rsp),
		.timerPinIn(pinIn), .timerPinOut(pinOut), .timerPinOe(pinOe), .counterCh0(count),
		.ch1CountPulse(step), .irq(irq));
	ccio_far_model #(.CNT_W(16)) ccio_far_model_i (.clk(clk), .run(run), .pinDrv(pinDrv),
		.pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn), .count(count), .stepPulse(step));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic drives(input logic [3:0] f);
		return !f[3] && (f[1:0] != 2'h0);
	endfunction : drives

	function automatic logic afterMatch(input logic [3:0] f);
		return (f[1:0] == 2'h3) ? !f[2] : f[1];
	endfunction : afterMatch

	function automatic logic capExp(input logic [3:0] f, input logic rise);
		return f[1] ? 1'b1 : (f[0] != rise);
	endfunction : capExp

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nCompared++;
		if (got !== exp)
		begin
			errTotal++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (rsp.awready)
				req.awvalid <= 1'b0;
			if (rsp.wready)
				req.wvalid <= 1'b0;
			if (rsp.bvalid)
			begin
				req.bready <= 1'b0;
				wrResp = rsp.bresp;
			end
		end while (req.bready);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (rsp.arready)
				req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
	endtask : rd

	task automatic endSim;
		if (errTotal == 0 && nCompared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : endSim

	initial
	begin
		repeat (20000) @(posedge clk);
		errTotal++;
		endSim();
	end

	initial
	begin
		errTotal = 0;
		nCompared = 0;
		reset = 1'b1;
		run = 1'b0;
		pinDrv = 2'h0;
		req = '0;
		void'($urandom(32'h12B9));
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		rd(ccio_pkg::OFS_IO_LOW, rdv, rsv);
		chk(rdv, 32'h0);
		rd(8'h1C, rdv, rsv);
		chk({30'h0, rsv}, {30'h0, ccio_pkg::RESP_DECERR});
		wr(8'h1C, 32'hFFFF_FFFF);
		chk({30'h0, wrResp}, {30'h0, ccio_pkg::RESP_DECERR});
		// every compare code on pin D while stopped, buffer mode at random
		for (int i = 0; i < 8; i++)
		begin
			code = i[3:0];
			v = {code, 4'($urandom)};
			bufD = 1'($urandom);
			wr(ccio_pkg::OFS_CTRL, {30'h0, bufD, 1'b0});
			wr(ccio_pkg::OFS_IO_LOW, {24'h0, v});
			rd(ccio_pkg::OFS_IO_LOW, rdv, rsv);
			chk(rdv, {24'h0, v});
			chk({28'h0, wrResp, rsv}, {28'h0, ccio_pkg::RESP_OKAY, ccio_pkg::RESP_OKAY});
			repeat (3) @(posedge clk);
			chk({31'h0, pinOe[1]}, {31'h0, drives(code) && !bufD});
			if (drives(code) && !bufD)
				chk({31'h0, pinOut[1]}, {31'h0, code[2]});
		end
		// compare match actions on pin B with interrupt masked and unmasked
		foreach (cmpCodes[i])
		begin
			code = cmpCodes[i];
			v = 8'h14 + 8'($urandom_range(19, 0));
			run <= 1'b0;
			wr(ccio_pkg::OFS_CTRL, 32'h0);
			wr(ccio_pkg::OFS_GR_B, {24'h0, v});
			rd(ccio_pkg::OFS_GR_B, rdv, rsv);
			chk(rdv, {24'h0, v});
			wr(ccio_pkg::OFS_IRQ_MASK, {31'h0, i[0]});
			wr(ccio_pkg::OFS_IRQ_STAT, 32'hF);
			wr(ccio_pkg::OFS_IO_HIGH, {24'h0, code, 4'h0});
			repeat (3) @(posedge clk);
			chk({31'h0, pinOut[0]}, {31'h0, code[2]});
			run <= 1'b1;
			wr(ccio_pkg::OFS_CTRL, 32'h1);
			chk({31'h0, pinOut[0]}, {31'h0, code[2]});
			repeat (40) @(posedge clk);
			chk({31'h0, pinOut[0]}, {31'h0, afterMatch(code)});
			chk({31'h0, irq}, {31'h0, i[0]});
			rd(ccio_pkg::OFS_IRQ_STAT, rdv, rsv);
			chk(rdv & 32'h1, 32'h1);
			wr(ccio_pkg::OFS_IRQ_STAT, 32'h1);
			repeat (2) @(posedge clk);
			chk({31'h0, irq}, 32'h0);
		end
		// pin capture edges on pin B
		for (int i = 8; i < 12; i++)
		begin
			code = i[3:0];
			wr(ccio_pkg::OFS_IO_HIGH, {24'h0, code, 4'h0});
			repeat (4) @(posedge clk);
			for (int e = 1; e >= 0; e--)
			begin
				wr(ccio_pkg::OFS_IRQ_STAT, 32'hF);
				pinDrv <= {1'b0, e[0]};
				repeat (8) @(posedge clk);
				rd(ccio_pkg::OFS_IRQ_STAT, rdv, rsv);
				chk(rdv & 32'h2, {30'h0, capExp(code, e[0]), 1'b0});
			end
		end
		// capture on channel 1 count steps, undivided prescale first
		wr(ccio_pkg::OFS_IO_HIGH, {24'h0, 4'hC | 4'($urandom_range(3, 0)), 4'h0});
		for (int p = 0; p < 2; p++)
		begin
			v = (p == 0) ? 8'h0 : 8'($urandom_range(7, 1));
			wr(ccio_pkg::OFS_CTRL, {27'h0, v[2:0], 2'h1});
			wr(ccio_pkg::OFS_IRQ_STAT, 32'hF);
			repeat (20) @(posedge clk);
			rd(ccio_pkg::OFS_IRQ_STAT, rdv, rsv);
			chk(rdv & 32'h2, {30'h0, p[0], 1'b0});
		end
		endSim();
	end
endmodule : tb_compare_capture_io_control
